/* design/hard_timer_counter_pwm.sv */
// 16-bit up/down timer/counter with compare, pwm and capture
`timescale 1ns/1ps
module hard_timer_counter_pwm #(
   parameter int CNT_W = timer_pkg::CNT_W,
   parameter int PRE_W = timer_pkg::PRE_W
) (
   input  wire logic                           clk,
   input  wire logic                           arst_n,
   input  wire logic                           count_clock_in,
   input  wire logic                           count_reset_n_in,
   input  wire logic                           reset_input_enable,
   input  wire logic                           capture_trigger_in,
   input  wire logic                           bus_mode,
   input  wire logic                           count_enable,
   input  wire logic                           clk_source_sel,
   input  wire logic [timer_pkg::PRE_SEL_W-1:0] prescale_sel,
   input  wire logic [1:0]                     mode_sel,
   input  wire logic                           count_down,
   input  wire logic [CNT_W-1:0]               top_value,
   input  wire logic [CNT_W-1:0]               compare_value,
   input  wire logic                           capture_enable,
   input  wire logic [timer_pkg::EV_N-1:0]     irq_mask,
   input  wire logic [timer_pkg::EV_N-1:0]     irq_clear,
   output logic                                irq_out,
   output logic                                wakeup_irq_out,
   output logic                                waveform_out,
   output logic [CNT_W-1:0]                    counter_value,
   output logic [CNT_W-1:0]                    capture_value_reg,
   output logic [timer_pkg::EV_N-1:0]          irq_status
);

   timer_pkg::mode_t          mode;
   logic [timer_pkg::SYNC_W-1:0] pin_level;
   logic [timer_pkg::SYNC_W-1:0] pin_rise;
   logic                      rst_ena_q;
   logic                      cfg_done_q;
   logic                      soft_rst;
   logic                      src_tick;
   logic [PRE_W-1:0]          pre_q;
   logic [PRE_W-1:0]          pre_mask;
   logic                      tick;
   logic [CNT_W-1:0]          top_q;
   logic [CNT_W-1:0]          cmp_q;
   logic                      up_q;
   logic                      pwm_mode;
   logic                      period_end;
   logic                      match;
   logic [CNT_W-1:0]          limit;
   logic [CNT_W-1:0]          cnt_d;
   logic                      up_d;
   logic [timer_pkg::EV_N-1:0] events;
   logic                      irq_d;

   // prescaler mask with the low sel bits set
   function automatic logic [PRE_W-1:0] low_mask(
      input logic [timer_pkg::PRE_SEL_W-1:0] sel
   );
      logic [PRE_W-1:0] m;
      m = '0;
      for (int i = 0; i < PRE_W; i++) begin
         if (i < int'(sel)) m[i] = 1'b1;
      end
      return m;
   endfunction

   assign mode = timer_pkg::mode_t'(mode_sel);
   assign pwm_mode = mode_sel[1];

   // ************************************************************
   // input synchronisers
   // ************************************************************
   // clock pin, capture pin and reset pin share one three-stage bank
   pin_sync #(
      .W     (timer_pkg::SYNC_W)
   ) u_sync (
      .clk   (clk),
      .arst_n(arst_n),
      .pin   ({count_reset_n_in, capture_trigger_in, count_clock_in}),
      .level (pin_level),
      .rise  (pin_rise)
   );

   // ************************************************************
   // configuration capture and reset input
   // ************************************************************
   // enable is caught once after release, then held for good
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_done_q <= 1'b0;
         rst_ena_q  <= 1'b0;
      end else if (!cfg_done_q) begin
         cfg_done_q <= 1'b1;
         rst_ena_q  <= reset_input_enable;
      end
   end

   // synced reset pin acts only when the enable was loaded
   assign soft_rst = rst_ena_q & ~pin_level[timer_pkg::LANE_RST];

   // ************************************************************
   // clock source and prescaler
   // ************************************************************
   assign src_tick = (clk_source_sel == timer_pkg::CLK_SRC_PIN) ?
                     pin_rise[timer_pkg::LANE_CLK] : 1'b1;
   assign pre_mask = low_mask(prescale_sel);
   assign tick = count_enable & src_tick &
                 ((pre_q & pre_mask) == pre_mask);

   // divider cleared while disabled or in soft reset, advanced by each source tick
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= timer_pkg::PRE_RST;
      end else if (soft_rst || !count_enable) begin
         pre_q <= timer_pkg::PRE_RST;
      end else if (src_tick) begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // ************************************************************
   // buffered period and compare
   // ************************************************************
   // pwm modes update only at period end or in soft reset so a new period never
   // cuts a pulse short; other modes take new values at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         top_q <= timer_pkg::TOP_RST;
         cmp_q <= timer_pkg::CMP_RST;
      end else if (soft_rst || !pwm_mode || (tick && period_end)) begin
         top_q <= top_value;
         cmp_q <= compare_value;
      end
   end

   // ************************************************************
   // counter next state
   // ************************************************************
   assign limit = (mode == timer_pkg::MODE_CTC) ? cmp_q : top_q;
   assign match = (counter_value == cmp_q);

   // period end and next count for each mode
   always_comb begin
      cnt_d      = counter_value;
      up_d       = up_q;
      period_end = 1'b0;
      case (mode)
         timer_pkg::MODE_WATCHDOG,
         timer_pkg::MODE_CTC: begin
            if (count_down) begin
               period_end = (counter_value == '0);
               cnt_d = period_end ? limit : counter_value - 1'b1;
            end else begin
               period_end = (counter_value >= limit);
               cnt_d = period_end ? '0 : counter_value + 1'b1;
            end
         end
         timer_pkg::MODE_FAST_PWM: begin
            period_end = (counter_value >= top_q);
            cnt_d = period_end ? '0 : counter_value + 1'b1;
         end
         timer_pkg::MODE_PFC_PWM: begin
            if (up_q) begin
               if (counter_value >= top_q) begin
                  up_d  = 1'b0;
                  cnt_d = (counter_value == '0) ? '0 :
                          counter_value - 1'b1;
               end else begin
                  cnt_d = counter_value + 1'b1;
               end
            end else begin
               if (counter_value == '0) begin
                  period_end = 1'b1; // bottom ends the period
                  up_d  = 1'b1;
                  cnt_d = (top_q == '0) ? '0 : 16'h0001;
               end else begin
                  cnt_d = counter_value - 1'b1;
               end
            end
         end
         default: begin
            cnt_d = counter_value;
         end
      endcase
   end

   // counter and direction registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         counter_value <= timer_pkg::CNT_RST;
         up_q          <= 1'b1;
      end else if (soft_rst) begin
         counter_value <= timer_pkg::CNT_RST;
         up_q          <= 1'b1;
      end else if (tick) begin
         counter_value <= cnt_d;
         up_q          <= up_d;
      end
   end

   // ************************************************************
   // events and capture
   // ************************************************************
   assign events[timer_pkg::EV_OVF] = tick & period_end;
   assign events[timer_pkg::EV_CMP] = tick & match;
   // capture honoured only in non-pwm modes on the host bus
   assign events[timer_pkg::EV_CAP] = pin_rise[timer_pkg::LANE_CAP] &
                                      capture_enable & bus_mode &
                                      !pwm_mode;

   // time stamp of the capture edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         capture_value_reg <= timer_pkg::CNT_RST;
      end else if (soft_rst) begin
         capture_value_reg <= timer_pkg::CNT_RST;
      end else if (events[timer_pkg::EV_CAP]) begin
         capture_value_reg <= counter_value;
      end
   end

   // sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= timer_pkg::EV_RST;
      end else if (soft_rst) begin
         irq_status <= timer_pkg::EV_RST;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | events;
      end
   end

   // ************************************************************
   // interrupt outputs
   // ************************************************************
   // the stand-alone overflow flag is the sticky overflow bit itself
   always_comb begin
      if (bus_mode) begin
         irq_d = |(irq_status & irq_mask);
      end else begin
         irq_d = irq_status[timer_pkg::EV_OVF];
      end
   end

   // both interrupt lines registered; wake-up mirrors the routed one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_out        <= 1'b0;
         wakeup_irq_out <= 1'b0;
      end else if (soft_rst) begin
         irq_out        <= 1'b0;
         wakeup_irq_out <= 1'b0;
      end else begin
         irq_out        <= irq_d;
         wakeup_irq_out <= irq_d;
      end
   end

   // ************************************************************
   // waveform output
   // ************************************************************
   // pwm level comes from registered compare against the buffered
   // threshold, so the pin only moves on a clock edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waveform_out <= 1'b0;
      end else if (soft_rst) begin
         waveform_out <= 1'b0;
      end else begin
         case (mode)
            timer_pkg::MODE_WATCHDOG: begin
               if (events[timer_pkg::EV_OVF]) begin
                  waveform_out <= ~waveform_out;
               end
            end
            timer_pkg::MODE_CTC: begin
               if (events[timer_pkg::EV_CMP]) begin
                  waveform_out <= ~waveform_out;
               end
            end
            timer_pkg::MODE_FAST_PWM,
            timer_pkg::MODE_PFC_PWM: begin
               waveform_out <= (counter_value < cmp_q);
            end
            default: begin
               waveform_out <= 1'b0;
            end
         endcase
      end
   end

endmodule

/* design/pin_sync.sv */
// three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // ************************************************************
   // flop chain, first stage feeds only the second
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= '0;
         rise  <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level[i] <= s3_q[i];
               rise[i]  <= s3_q[i] & ~level[i];
            end else begin
               rise[i]  <= 1'b0;
            end
         end
      end
   end

endmodule

/* design/timer_pkg.sv */
// shared constants and types of the timer/counter
package timer_pkg;

   // ************************************************************
   // widths and sizes
   // ************************************************************
   localparam int CNT_W      = 16;
   localparam int PRE_W      = 10;
   localparam int PRE_SEL_W  = 4;
   localparam int SYNC_W     = 3;

   // ************************************************************
   // operating modes
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_WATCHDOG = 2'b00,
      MODE_CTC      = 2'b01,
      MODE_FAST_PWM = 2'b10,
      MODE_PFC_PWM  = 2'b11
   } mode_t;

   // clock source select codes
   localparam logic CLK_SRC_SYS = 1'b0;
   localparam logic CLK_SRC_PIN = 1'b1;

   // ************************************************************
   // field positions of the event vector and synchroniser lanes
   // ************************************************************
   localparam int EV_OVF  = 0;
   localparam int EV_CMP  = 1;
   localparam int EV_CAP  = 2;
   localparam int EV_N    = 3;
   localparam int LANE_CLK = 0;
   localparam int LANE_CAP = 1;
   localparam int LANE_RST = 2;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
   localparam logic [CNT_W-1:0] TOP_RST  = 16'hFFFF;
   localparam logic [CNT_W-1:0] CMP_RST  = 16'h0000;
   localparam logic [PRE_W-1:0] PRE_RST  = 10'h000;
   localparam logic [EV_N-1:0]  EV_RST   = 3'h0;
   localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;

endpackage

/* sim/fabric_model.sv */
// fabric-side model driving the count clock and capture pins
`timescale 1ns/1ps
module fabric_model (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       run_pin_clk,
   input  wire logic [3:0] half_period,
   input  wire logic       cap_level,
   output logic            count_clock_in,
   output logic            capture_trigger_in
);
   logic [3:0] phase_q;
   // pin clock stands still low outside bursts; slow or fast by half_period
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n || !run_pin_clk) begin
         phase_q        <= 4'h0;
         count_clock_in <= 1'b0;
      end else if (phase_q == half_period - 4'h1) begin
         phase_q        <= 4'h0;
         count_clock_in <= !count_clock_in;
      end else begin
         phase_q <= phase_q + 4'h1;
      end
   end
   // capture pin follows the request one clock later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         capture_trigger_in <= 1'b0;
      end else begin
         capture_trigger_in <= cap_level;
      end
   end
endmodule

/* sim/test_hard_timer_counter_pwm.sv */
// self-checking bench for the timer/counter
`timescale 1ns/1ps
module test_hard_timer_counter_pwm;
   logic clk, arst_n, count_clock_in, count_reset_n_in, reset_input_enable;
   logic capture_trigger_in, bus_mode, count_enable, clk_source_sel;
   logic count_down, capture_enable, irq_out, wakeup_irq_out, waveform_out;
   logic run_pin_clk, cap_level;
   logic [3:0]  prescale_sel, half_period;
   logic [1:0]  mode_sel;
   logic [2:0]  irq_mask, irq_clear, irq_status;
   logic [15:0] top_value, compare_value, counter_value, capture_value_reg, v;
   int fails, total_checks, n, hi, rs;

   hard_timer_counter_pwm DUT (.clk, .arst_n, .count_clock_in,
      .count_reset_n_in, .reset_input_enable, .capture_trigger_in, .bus_mode,
      .count_enable, .clk_source_sel, .prescale_sel, .mode_sel, .count_down,
      .top_value, .compare_value, .capture_enable, .irq_mask, .irq_clear,
      .irq_out, .wakeup_irq_out, .waveform_out, .counter_value,
      .capture_value_reg, .irq_status);
   fabric_model u_fabric (.clk, .arst_n, .run_pin_clk, .half_period,
      .cap_level, .count_clock_in, .capture_trigger_in);

   // free-running 100 MHz clock
   always #5 clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // sample just after an edge so its updates have landed
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wait_cnt(input logic [15:0] x);
      int w;
      w = 0;
      while (counter_value !== x) begin
         cyc(1);
         w++;
         if (w > 3000) begin
            fails++;
            final_report();
         end
      end
   endtask
   // full reset, buffers loaded in mode 00, then the wanted mode runs
   task automatic setup(input logic [1:0] m, input logic [3:0] ps,
                        input logic [15:0] t, input logic [15:0] c);
      @(posedge clk);
      arst_n <= 1'b0;
      count_enable <= 1'b0;
      mode_sel <= 2'b00;
      prescale_sel <= ps;
      top_value <= t;
      compare_value <= c;
      cyc(1);
      check(counter_value, 16'h0000);
      @(posedge clk) arst_n <= 1'b1;
      repeat (6) @(posedge clk);
      mode_sel <= m;
      @(posedge clk) count_enable <= 1'b1;
      #1;
   endtask
   task automatic measure(input int k);
      logic p;
      hi = 0;
      rs = 0;
      p = waveform_out;
      repeat (k) begin
         cyc(1);
         if (waveform_out === 1'b1) hi++;
         if (waveform_out === 1'b1 && p === 1'b0) rs++;
         p = waveform_out;
      end
   endtask
   // capture pulse; the synchroniser must hide it for several cycles
   task automatic cap_pulse();
      @(posedge clk) cap_level <= 1'b1;
      cyc(4);
      check(16'(irq_status[2]), 16'h0000);
      cyc(8);
      @(posedge clk) cap_level <= 1'b0;
      #1;
   endtask

   initial begin
      clk = 1'b0; arst_n = 1'b0; run_pin_clk = 1'b0; half_period = 4'h4;
      cap_level = 1'b0; count_reset_n_in = 1'b1; reset_input_enable = 1'b0;
      bus_mode = 1'b0; count_enable = 1'b0; clk_source_sel = 1'b0;
      prescale_sel = 4'h0; mode_sel = 2'b00; count_down = 1'b0;
      top_value = 16'hFFFF; compare_value = 16'hFFFF; capture_enable = 1'b0;
      irq_mask = 3'h0; irq_clear = 3'h0; fails = 0; total_checks = 0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      // fast pwm wrap at top 2, flags and stand-alone irq
      setup(2'b10, 4'h0, 16'h0002, 16'h0001);
      wait_cnt(16'h0002);
      cyc(1);
      check(counter_value, 16'h0000);
      check(16'(irq_status), 16'h0003);
      cyc(1);
      check({14'h0, wakeup_irq_out, irq_out}, 16'h0003);
      // pwm duty, then a period change on the fly
      setup(2'b10, 4'h0, 16'h0009, 16'h0004);
      cyc(20);
      measure(40);
      check(16'(hi), 16'h0010);
      check(16'(rs), 16'h0004);
      @(posedge clk) top_value <= 16'h0013;
      cyc(40);
      measure(40);
      check(16'(hi), 16'h0008);
      check(16'(rs), 16'h0002);
      // watchdog and clear-on-match toggle once per period of five
      for (int m = 0; m < 2; m++) begin
         setup(2'(m), 4'h0, 16'h0004, 16'h0004);
         cyc(10);
         measure(40);
         check(16'(rs), 16'h0004);
      end
      // phase-correct pwm turns round at the top
      setup(2'b11, 4'h0, 16'h0009, 16'h0004);
      wait_cnt(16'h0009);
      cyc(1);
      check(counter_value, 16'h0008);
      // prescaler divides by powers of two
      for (int p = 0; p < 4; p++) begin
         setup(2'b00, 4'(p), 16'hFFFF, 16'hFFFF);
         wait_cnt(16'h0002);
         n = 0;
         while (counter_value === 16'h0002 && n < 100) begin
            cyc(1);
            n++;
         end
         check(16'(n), 16'(1 << p));
      end
      // down counting reloads the limit after zero
      @(posedge clk) count_down <= 1'b1;
      setup(2'b00, 4'h0, 16'h0005, 16'h0005);
      wait_cnt(16'h0001);
      cyc(1);
      check(counter_value, 16'h0000);
      cyc(1);
      check(counter_value, 16'h0005);
      // pin clock source, period of eight clocks, then idle
      @(posedge clk) count_down <= 1'b0;
      clk_source_sel <= 1'b1;
      run_pin_clk <= 1'b1;
      setup(2'b00, 4'h0, 16'hFFFF, 16'hFFFF);
      wait_cnt(16'h0001);
      cyc(84);
      check(counter_value, 16'h000B);
      @(posedge clk) run_pin_clk <= 1'b0;
      cyc(8);
      v = counter_value;
      cyc(20);
      check(counter_value, v);
      // capture in bus mode with the counter frozen
      @(posedge clk) clk_source_sel <= 1'b0;
      bus_mode <= 1'b1;
      capture_enable <= 1'b1;
      irq_mask <= 3'b100;
      setup(2'b01, 4'h0, 16'h0100, 16'h0100);
      cyc(20);
      @(posedge clk) count_enable <= 1'b0;
      cyc(2);
      v = counter_value;
      cap_pulse();
      check(capture_value_reg, v);
      check({13'h0, irq_status[2], wakeup_irq_out, irq_out}, 16'h0007);
      @(posedge clk) irq_clear <= 3'b100;
      @(posedge clk) irq_clear <= 3'b000;
      cyc(2);
      check({13'h0, irq_status[2], 1'b0, irq_out}, 16'h0000);
      // capture refused in pwm and in stand-alone mode
      setup(2'b10, 4'h0, 16'h0100, 16'h0010);
      cap_pulse();
      check(16'(irq_status[2]), 16'h0000);
      @(posedge clk) bus_mode <= 1'b0;
      setup(2'b01, 4'h0, 16'h0100, 16'h0100);
      cap_pulse();
      check(16'(irq_status[2]), 16'h0000);
      // direct reset pin, live when enabled at configuration
      for (int e = 1; e >= 0; e--) begin
         @(posedge clk) reset_input_enable <= 1'(e);
         setup(2'b00, 4'h0, 16'hFFFF, 16'h0004);
         cyc(10);
         @(posedge clk) count_reset_n_in <= 1'b0;
         cyc(8);
         check(16'(counter_value == 16'h0000), 16'(e));
         check({14'h0, waveform_out, irq_out}, 16'h0000);
         check(16'(irq_status), e ? 16'h0000 : 16'h0002);
         @(posedge clk) count_reset_n_in <= 1'b1;
         cyc(10);
         check(16'(counter_value != 16'h0000), 16'h0001);
      end
      final_report();
   end
endmodule

bind hard_timer_counter_pwm timer_properties #(.CNT_W(CNT_W)) u_props (
   .clk, .arst_n, .bus_mode, .count_enable, .mode_sel, .compare_value,
   .capture_enable, .irq_mask, .irq_clear, .irq_out, .wakeup_irq_out,
   .waveform_out, .counter_value, .capture_value_reg, .irq_status);

/* sim/timer_properties.sv */
// concurrent port checks for the timer/counter
`timescale 1ns/1ps
module timer_properties #(
   parameter int CNT_W = 16
) (
   input wire logic                       clk,
   input wire logic                       arst_n,
   input wire logic                       bus_mode,
   input wire logic                       count_enable,
   input wire logic [1:0]                 mode_sel,
   input wire logic [CNT_W-1:0]           compare_value,
   input wire logic                       capture_enable,
   input wire logic [timer_pkg::EV_N-1:0] irq_mask,
   input wire logic [timer_pkg::EV_N-1:0] irq_clear,
   input wire logic                       irq_out,
   input wire logic                       wakeup_irq_out,
   input wire logic                       waveform_out,
   input wire logic [CNT_W-1:0]           counter_value,
   input wire logic [CNT_W-1:0]           capture_value_reg,
   input wire logic [timer_pkg::EV_N-1:0] irq_status
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // a stopped counter must not creep
   property p_hold;
      !$past(count_enable) |-> $stable(counter_value);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved");
   // fast pwm wrap raises the overflow flag in the same cycle
   property p_wrap;
      mode_sel == 2'b10 && $past(mode_sel) == 2'b10 && counter_value == '0
      && $past(counter_value) != '0 |-> irq_status[0];
   endproperty
   a_wrap: assert property (p_wrap) else $error("no overflow flag");
   property p_pwm;
      mode_sel[1] && $past(mode_sel[1]) && $past(compare_value) == compare_value
      |-> waveform_out == ($past(counter_value) < compare_value);
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm level wrong");
   property p_cap_src;
      $rose(irq_status[2]) |-> $past(capture_enable) && $past(bus_mode)
      && !$past(mode_sel[1]);
   endproperty
   a_cap_src: assert property (p_cap_src) else $error("bad capture");
   property p_cap_val;
      $rose(irq_status[2]) |-> capture_value_reg == $past(counter_value);
   endproperty
   a_cap_val: assert property (p_cap_val) else $error("stamp wrong");
   property p_bus_irq;
      $past(bus_mode) |-> irq_out == |($past(irq_status) & $past(irq_mask));
   endproperty
   a_bus_irq: assert property (p_bus_irq) else $error("bus irq");
   property p_ovf_irq;
      !$past(bus_mode) |-> irq_out == $past(irq_status[0]);
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("ovf irq");
   property p_wake;
      wakeup_irq_out == irq_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake differs");
   // the overflow flag is sticky until cleared
   property p_sticky;
      irq_status[0] && !irq_clear[0] |=> irq_status[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule
